// ### verification/in_system_flash_programming_tb.sv
// self-checking bench for the flash programming block
`timescale 1ns/10ps
module in_system_flash_programming_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, jump_go = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_w;
    logic [1:0]  bresp, rresp, resp;
    logic        awready, wready, bvalid, arready, rvalid, freq, jump, exec_boot, st_v;
    logic [15:0] faddr, st_a;
    logic        ret = 1'b0, rld_en = 1'b0, fvalid;
    logic [9:0]  rld_a = 10'h000;
    logic [7:0]  rld_d = 8'h00, fdata;
    int          err_total = 0, comparisons = 0;
    always #4 aclk = ~aclk;
    isp_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .fetch_req(freq), .fetch_addr(faddr), .fetch_valid_q(fvalid),
        .fetch_data_q(fdata), .jump_to_boot_rom(jump), .return_to_flash(ret),
        .exec_boot_q(exec_boot), .start_valid_q(st_v), .start_addr_q(st_a),
        .rom_load_en(rld_en), .rom_load_addr(rld_a), .rom_load_data(rld_d));
    isp_core_model core (.aclk(aclk), .jump_go(jump_go), .fetch_req(freq),
        .fetch_addr(faddr), .jump_to_boot_rom(jump));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_w = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // select bit is sampled again on every reset
    task automatic rst();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        #1 chk(st_v, 1);
        chk(st_a, 16'h0000);
    endtask
    task automatic unlock();
        wr(8'h18, 8'h98);
        jump_go <= 1'b1;
        @(posedge aclk);
        jump_go <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(exec_boot, 1);
    endtask
    // leave boot mode; wrong key, lapsed key and a jump without key all stay out
    task automatic key_expiry();
        @(posedge aclk);
        ret <= 1'b1;
        @(posedge aclk);
        ret <= 1'b0;
        @(posedge aclk);
        chk(exec_boot, 0);
        wr(8'h18, 8'h9C);
        rd(8'h18);
        chk(rd_w, 32'h0);
        wr(8'h18, 8'h98);
        rd(8'h18);
        chk(rd_w, 32'h1);
        repeat (40) @(posedge aclk);
        rd(8'h18);
        chk(rd_w, 32'h0);
        jump_go <= 1'b1;
        @(posedge aclk);
        jump_go <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(exec_boot, 0);
    endtask
    // boot rom loaded through the factory port, then one fetch traced through
    task automatic rom_fetch();
        logic [15:0] a;
        for (int i = 0; i < 1024; i++) begin
            @(posedge aclk);
            rld_en <= 1'b1;
            rld_a <= 10'(i);
            rld_d <= 8'(i) ^ 8'h5A;
        end
        @(posedge aclk);
        rld_en <= 1'b0;
        #1 a = faddr;
        repeat (2) @(posedge aclk);
        #1 chk(fvalid, 1);
        chk(fdata, a[7:0] ^ 8'h5A);
    endtask
    // long erase: poll busy with a bound rather than a fixed wait
    task automatic cmd(input logic [7:0] c);
        wr(8'h14, c);
        repeat (20000) begin
            rd(8'h14);
            if (rd_w[7] === 1'b0) break;
        end
        chk(rd_w[7], 1'b0);
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000 err_total++;
        give_verdict();
    end
    initial begin
        rst();
        rd(8'h00);
        chk(rd_w, 32'h0);
        rd(8'h04);
        chk(rd_w, 32'h0);
        rd(8'h10);
        chk(rd_w, 32'h7B);
        wr(8'h30, 8'h01);
        chk(resp, 2'h2);
        key_expiry();
        unlock();
        rom_fetch();
        wr(8'h10, 8'h00);
        cmd(8'h08);
        rst();
        chk(exec_boot, 1);
        unlock();
        wr(8'h10, 8'h00);
        wr(8'h00, 8'hFF);
        wr(8'h04, 8'hFF);
        wr(8'h0C, 8'h01);
        cmd(8'h02);
        cmd(8'h01);
        rd(8'h08);
        chk(rd_w, 32'h01);
        rd(8'h00);
        chk(rd_w, 32'hFF);
        rst();
        chk(exec_boot, 0);
        wr(8'h14, 8'h01);
        chk(resp, 2'h2);
        rd(8'h14);
        chk(resp, 2'h2);
        chk(rd_w, 32'h0);
        give_verdict();
    end
endmodule // in_system_flash_programming_tb

// ### verification/isp_core_model.sv
// core model: fetch stream and boot jump pulses
`timescale 1ns/10ps
module isp_core_model (
    // clock
    input  wire logic   aclk,
    // bench request
    input  wire logic   jump_go,
    // core side
    output logic        fetch_req,
    output logic [15:0] fetch_addr,
    output logic        jump_to_boot_rom
);
    initial fetch_req = 1'b0;
    initial fetch_addr = 16'h0000;
    initial jump_to_boot_rom = 1'b0;
    always @(posedge aclk) begin
        fetch_req <= 1'b1;
        fetch_addr <= fetch_addr + 16'h0001;
        jump_to_boot_rom <= jump_go;
    end
endmodule // isp_core_model

// ### verilog/isp_mem.sv
// byte-wide memory with registered read data
`timescale 1ns/10ps
module isp_mem #(
    parameter int AW = 10
) (
    // clock
    input wire logic aclk,
    // access port
    isp_mem_if.mem   port
);
    // arrays start erased, as on an unprogrammed part; no unknown select bit at first boot
    logic [7:0] mem_q [0:(1<<AW)-1] = '{default: isp_pkg::ERASED_BYTE};

    always_ff @(posedge aclk) begin
        if (port.we) begin
            mem_q[port.waddr] <= port.wdata;
        end
        if (port.re) begin
            port.rdata <= mem_q[port.raddr];
        end
    end
endmodule // isp_mem

// ### verilog/isp_mem_if.sv
// byte memory port shared between the sequencer and its memories
`timescale 1ns/10ps
interface isp_mem_if #(parameter int AW = 10);
    logic          we;
    logic [AW-1:0] waddr;
    logic [7:0]    wdata;
    logic          re;
    logic [AW-1:0] raddr;
    logic [7:0]    rdata;
    modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
    modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// ### verilog/isp_pkg.sv
// constants and types for the in-system flash programming block
// What this block does
// - boot select 0 leaves reset in boot ROM
// - boot select 1 starts flash at 0000
// - 1k boot ROM present; custom routines in flash
// - address from high/low bytes, both reset 00
// - either code loads address at any time; holding it during operation is up to software
// - read operation leaves byte in read register
// - write takes its byte from write register
// - seven registers; control hidden from user code
// - boot jump needs key; flag lasts 8 instruction cycles of 4 clocks each
package isp_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_ADDR_HIGH  = 8'h00;
    localparam logic [7:0] OFF_ADDR_LOW   = 8'h04;
    localparam logic [7:0] OFF_READ_BYTE  = 8'h08;
    localparam logic [7:0] OFF_WRITE_BYTE = 8'h0C;
    localparam logic [7:0] OFF_TIMING     = 8'h10;
    localparam logic [7:0] OFF_CONTROL    = 8'h14;
    localparam logic [7:0] OFF_KEY        = 8'h18;
    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_RESET    = 8'h00;
    localparam logic [7:0]  TIMING_RESET  = 8'h7B;
    localparam logic [5:0]  KEY_VALUE     = 6'h26;
    localparam int          KEY_LSB       = 2;
    localparam logic [3:0]  KEY_CYCLES    = 4'h8;
    localparam logic [3:0]  INSTR_CLKS    = 4'h4;
    localparam int          CTL_READ      = 0;
    localparam int          CTL_WRITE     = 1;
    localparam int          CTL_PAGE      = 2;
    localparam int          CTL_MASS      = 3;
    localparam int          CTL_BUSY      = 7;
    localparam int          FLEX_BIT      = 0;
    // ------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------
    localparam int          FLASH_AW      = 13;
    localparam int          ROM_AW        = 10;
    localparam int          PAGE_AW       = 6;
    localparam logic [12:0] OPTION_PHYS   = 13'h1FFF;
    localparam logic [15:0] OPTION_ALIAS  = 16'hFFFF;
    localparam logic [12:0] PAGE_MASK     = 13'h003F;
    localparam logic [12:0] MASS_LAST     = 13'h1FFF;
    localparam logic [7:0]  ERASED_BYTE   = 8'h00;
    localparam logic [15:0] START_ADDR    = 16'h0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        ST_SENSE, ST_SENSE_WAIT, ST_IDLE, ST_READ, ST_READ_DONE, ST_PROG
    } isp_state_type;
endpackage

// ### verilog/isp_pulse.sv
// write/erase pulse timer, width set by the timing register
`timescale 1ns/10ps
module isp_pulse (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       start,
    input  wire logic [7:0] width,
    // status
    output logic            busy_q,
    output logic            done_q
);
    logic [7:0] cnt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                cnt_q  <= width;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q == 8'h00) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
        end
    end
endmodule // isp_pulse

// ### verilog/isp_top.sv
// in-system flash programming registers, sequencer and boot source select
`timescale 1ns/10ps
module isp_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // core instruction fetch
    input  wire logic        fetch_req,
    input  wire logic [15:0] fetch_addr,
    output logic             fetch_valid_q,
    output logic [7:0]       fetch_data_q,
    // core flow control
    input  wire logic        jump_to_boot_rom,
    input  wire logic        return_to_flash,
    output logic             exec_boot_q,
    output logic             start_valid_q,
    output logic [15:0]      start_addr_q,
    // factory boot rom load
    input  wire logic        rom_load_en,
    input  wire logic [9:0]  rom_load_addr,
    input  wire logic [7:0]  rom_load_data
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    isp_pkg::isp_state_type state_q;
    logic [7:0]  prog_addr_high_q, prog_addr_low_q, prog_read_byte_q, prog_write_byte_q;
    logic [7:0]  write_pulse_timing_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic        w_strb0_q;
    logic        cmd_go_q;
    logic [3:0]  cmd_op_q;
    logic        erase_q;
    logic [12:0] ptr_q, last_q;
    logic [3:0]  instr_cnt_q, key_left_q;
    logic        fetch_v1_q, fetch_boot1_q;
    logic        pulse_busy, pulse_done;

    isp_mem_if #(.AW(isp_pkg::FLASH_AW)) flash_if ();
    isp_mem_if #(.AW(isp_pkg::ROM_AW))   rom_if ();

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire [15:0] prog_addr   = {prog_addr_high_q, prog_addr_low_q};
    wire [12:0] flash_addr  = (prog_addr == isp_pkg::OPTION_ALIAS) ?
                              isp_pkg::OPTION_PHYS : prog_addr[12:0];
    wire        wr_go       = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire        wr_lane     = wr_go && w_strb0_q;
    wire        wr_hi       = aw_addr_q == isp_pkg::OFF_ADDR_HIGH;
    wire        wr_lo       = aw_addr_q == isp_pkg::OFF_ADDR_LOW;
    wire        wr_rd       = aw_addr_q == isp_pkg::OFF_READ_BYTE;
    wire        wr_wb       = aw_addr_q == isp_pkg::OFF_WRITE_BYTE;
    wire        wr_tm       = aw_addr_q == isp_pkg::OFF_TIMING;
    wire        wr_ct       = aw_addr_q == isp_pkg::OFF_CONTROL;
    wire        wr_ky       = aw_addr_q == isp_pkg::OFF_KEY;
    wire        wr_bad      = !(wr_hi || wr_lo || wr_rd || wr_wb || wr_tm || wr_ky)
                              && !(wr_ct && exec_boot_q);
    wire        idle        = state_q == isp_pkg::ST_IDLE;
    wire [3:0]  new_op      = w_data_q[3:0];
    wire        key_hit     = wr_lane && wr_ky &&
                              (w_data_q[7:isp_pkg::KEY_LSB] == isp_pkg::KEY_VALUE);
    wire        key_flag    = key_left_q != 4'h0;
    wire        instr_tick  = instr_cnt_q == (isp_pkg::INSTR_CLKS - 4'h1);
    wire        ar_go       = s_axi_arvalid && s_axi_arready;
    wire        rd_hi       = s_axi_araddr == isp_pkg::OFF_ADDR_HIGH;
    wire        rd_lo       = s_axi_araddr == isp_pkg::OFF_ADDR_LOW;
    wire        rd_rd       = s_axi_araddr == isp_pkg::OFF_READ_BYTE;
    wire        rd_wb       = s_axi_araddr == isp_pkg::OFF_WRITE_BYTE;
    wire        rd_tm       = s_axi_araddr == isp_pkg::OFF_TIMING;
    wire        rd_ct       = (s_axi_araddr == isp_pkg::OFF_CONTROL) && exec_boot_q;
    wire        rd_ky       = s_axi_araddr == isp_pkg::OFF_KEY;
    wire        rd_ok       = rd_hi || rd_lo || rd_rd || rd_wb || rd_tm || rd_ct || rd_ky;
    wire [7:0]  ctl_view    = {!idle, 3'b000, cmd_op_q};
    wire [7:0]  rd_byte     = rd_hi ? prog_addr_high_q :
                              rd_lo ? prog_addr_low_q :
                              rd_rd ? prog_read_byte_q :
                              rd_wb ? prog_write_byte_q :
                              rd_tm ? write_pulse_timing_q :
                              rd_ct ? ctl_view :
                              rd_ky ? {7'h00, key_flag} : 8'h00;

    // ------------------------------------------------------------
    // sequencer datapath
    // ------------------------------------------------------------
    wire        op_prog     = cmd_op_q[isp_pkg::CTL_WRITE] || cmd_op_q[isp_pkg::CTL_PAGE]
                              || cmd_op_q[isp_pkg::CTL_MASS];
    wire        prog_start  = idle && cmd_go_q && !cmd_op_q[isp_pkg::CTL_READ] && op_prog;
    wire        erase_more  = (state_q == isp_pkg::ST_PROG) && pulse_done && erase_q
                              && (ptr_q != last_q);
    wire        seq_re      = (state_q == isp_pkg::ST_SENSE) || (state_q == isp_pkg::ST_READ);
    wire        is_erase    = !cmd_op_q[isp_pkg::CTL_WRITE];
    wire [12:0] start_ptr   = cmd_op_q[isp_pkg::CTL_MASS] && !cmd_op_q[isp_pkg::CTL_PAGE] ?
                              13'h0000 : (flash_addr & ~isp_pkg::PAGE_MASK);
    wire [12:0] end_ptr     = cmd_op_q[isp_pkg::CTL_MASS] && !cmd_op_q[isp_pkg::CTL_PAGE] ?
                              isp_pkg::MASS_LAST : (flash_addr | isp_pkg::PAGE_MASK);

    assign flash_if.re    = seq_re || (fetch_req && !exec_boot_q && idle);
    assign flash_if.raddr = (state_q == isp_pkg::ST_SENSE) ? isp_pkg::OPTION_PHYS :
                            (state_q == isp_pkg::ST_READ) ? flash_addr :
                            fetch_addr[12:0];
    assign flash_if.we    = (state_q == isp_pkg::ST_PROG) && pulse_done;
    assign flash_if.waddr = erase_q ? ptr_q : flash_addr;
    assign flash_if.wdata = erase_q ? isp_pkg::ERASED_BYTE : prog_write_byte_q;
    assign rom_if.re      = fetch_req && exec_boot_q;
    assign rom_if.raddr   = fetch_addr[9:0];
    assign rom_if.we      = rom_load_en;
    assign rom_if.waddr   = rom_load_addr;
    assign rom_if.wdata   = rom_load_data;

    isp_mem #(.AW(isp_pkg::FLASH_AW)) u_flash (.aclk(aclk), .port(flash_if.mem));
    isp_mem #(.AW(isp_pkg::ROM_AW))   u_rom   (.aclk(aclk), .port(rom_if.mem));

    isp_pulse u_pulse (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (prog_start || erase_more),
        .width   (write_pulse_timing_q),
        .busy_q  (pulse_busy),
        .done_q  (pulse_done)
    );

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= isp_pkg::RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= isp_pkg::RESP_OKAY;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb0_q     <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr_q     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data_q     <= s_axi_wdata;
                w_strb0_q    <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_bad ? isp_pkg::RESP_SLVERR : isp_pkg::RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (ar_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, rd_byte};
                s_axi_rresp   <= rd_ok ? isp_pkg::RESP_OKAY : isp_pkg::RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // both code sources may load the address and timing registers at any time, control only boot code when idle; holding them is up to software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_addr_high_q     <= isp_pkg::ADDR_RESET;
            prog_addr_low_q      <= isp_pkg::ADDR_RESET;
            write_pulse_timing_q <= isp_pkg::TIMING_RESET;
            cmd_go_q             <= 1'b0;
            cmd_op_q             <= 4'h0;
        end else begin
            cmd_go_q <= 1'b0;
            if (wr_lane && wr_hi) begin
                prog_addr_high_q <= w_data_q[7:0];
            end
            if (wr_lane && wr_lo) begin
                prog_addr_low_q <= w_data_q[7:0];
            end
            if (wr_lane && wr_tm) begin
                write_pulse_timing_q <= w_data_q[7:0];
            end
            if (wr_lane && wr_ct && exec_boot_q && idle && (new_op != 4'h0)) begin
                cmd_go_q <= 1'b1;
                cmd_op_q <= new_op;
            end
        end
    end

    // data registers carry no reset: their content is undefined until used
    always_ff @(posedge aclk) begin
        if (wr_lane && wr_wb) begin
            prog_write_byte_q <= w_data_q[7:0];
        end
        if (state_q == isp_pkg::ST_READ_DONE) begin
            prog_read_byte_q <= flash_if.rdata;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q       <= isp_pkg::ST_SENSE;
            erase_q       <= 1'b0;
            ptr_q         <= 13'h0000;
            last_q        <= 13'h0000;
            start_valid_q <= 1'b0;
            start_addr_q  <= isp_pkg::START_ADDR;
        end else begin
            start_valid_q <= 1'b0;
            unique case (state_q)
                isp_pkg::ST_SENSE: state_q <= isp_pkg::ST_SENSE_WAIT;
                isp_pkg::ST_SENSE_WAIT: begin
                    start_valid_q <= 1'b1;
                    start_addr_q  <= isp_pkg::START_ADDR;
                    state_q       <= isp_pkg::ST_IDLE;
                end
                isp_pkg::ST_IDLE: begin
                    if (cmd_go_q && cmd_op_q[isp_pkg::CTL_READ]) begin
                        state_q <= isp_pkg::ST_READ;
                    end else if (prog_start) begin
                        state_q <= isp_pkg::ST_PROG;
                        erase_q <= is_erase;
                        ptr_q   <= start_ptr;
                        last_q  <= end_ptr;
                    end
                end
                isp_pkg::ST_READ:      state_q <= isp_pkg::ST_READ_DONE;
                isp_pkg::ST_READ_DONE: state_q <= isp_pkg::ST_IDLE;
                isp_pkg::ST_PROG: begin
                    if (erase_more) begin
                        ptr_q <= ptr_q + 13'h0001;
                    end else if (pulse_done) begin
                        state_q <= isp_pkg::ST_IDLE;
                        erase_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // boot source, key and fetch
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exec_boot_q   <= 1'b1;
            instr_cnt_q   <= 4'h0;
            key_left_q    <= 4'h0;
            fetch_v1_q    <= 1'b0;
            fetch_boot1_q <= 1'b0;
            fetch_valid_q <= 1'b0;
            fetch_data_q  <= 8'h00;
        end else begin
            instr_cnt_q <= instr_tick ? 4'h0 : instr_cnt_q + 4'h1;
            if (key_hit) begin
                key_left_q <= isp_pkg::KEY_CYCLES;
            end else if (instr_tick && key_flag) begin
                key_left_q <= key_left_q - 4'h1;
            end
            if (state_q == isp_pkg::ST_SENSE_WAIT) begin
                exec_boot_q <= !flash_if.rdata[isp_pkg::FLEX_BIT];
            end else if (jump_to_boot_rom && key_flag) begin
                exec_boot_q <= 1'b1;
            end else if (return_to_flash) begin
                exec_boot_q <= 1'b0;
            end
            fetch_v1_q    <= rom_if.re || (flash_if.re && !seq_re);
            fetch_boot1_q <= exec_boot_q;
            fetch_valid_q <= fetch_v1_q;
            if (fetch_v1_q) begin
                fetch_data_q <= fetch_boot1_q ? rom_if.rdata : flash_if.rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_boot_from_flex: assert property (
        (state_q == isp_pkg::ST_SENSE_WAIT)
        |=> (exec_boot_q == !$past(flash_if.rdata[isp_pkg::FLEX_BIT])) && start_valid_q)
        else $error("boot source does not follow the select bit");
    a_start_at_zero: assert property (
        $rose(start_valid_q) |-> (start_addr_q == 16'h0000) && $past(state_q, 1)
        == isp_pkg::ST_SENSE_WAIT)
        else $error("start address not zero after reset");
    a_rom_fetch_path: assert property (
        (fetch_req && exec_boot_q && idle) |-> ##2 fetch_valid_q && fetch_data_q
        == $past(u_rom.mem_q[fetch_addr[9:0]], 2))
        else $error("boot rom fetch returned wrong byte");
    a_addr_cleared: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> (prog_addr_high_q == 8'h00) && (prog_addr_low_q == 8'h00))
        else $error("address registers not cleared by reset");
    a_addr_load: assert property (
        (wr_lane && wr_lo) |=> (prog_addr_low_q == $past(w_data_q[7:0])) && s_axi_bvalid)
        else $error("address low byte not loaded");
    a_read_lands: assert property (
        (cmd_go_q && idle && cmd_op_q[isp_pkg::CTL_READ]) |-> ##3
        prog_read_byte_q == $past(u_flash.mem_q[flash_addr], 2))
        else $error("read byte not captured");
    a_write_data: assert property (
        (flash_if.we && !erase_q) |-> flash_if.wdata == prog_write_byte_q
        && flash_if.waddr == flash_addr)
        else $error("programmed byte not from write register");
    a_ctrl_hidden: assert property (
        (wr_go && wr_ct && !exec_boot_q) |=> s_axi_bresp == isp_pkg::RESP_SLVERR
        && !cmd_go_q)
        else $error("control register reached from user code");
    a_key_window: assert property (
        key_hit |=> key_left_q == 4'h8)
        else $error("key flag window wrong length");
    a_jump_no_key: assert property (
        (jump_to_boot_rom && !key_flag && !exec_boot_q && idle
        && state_q != isp_pkg::ST_SENSE_WAIT) |=> !exec_boot_q)
        else $error("boot jump taken without key");
endmodule // isp_top
